/* File: pmx_pkg.sv */
// Purpose: Shared constants and carrier types for the port A/B pin-function mux
// Assumes: Pin vector packs first port lines 10..0 at 10..0, second port 27..31 at 11..15
// Notes:   Select codes are Gray along GPIO, ALT1, ALT2, ALT3, ALT4
package pmx_pkg;

   // ==========================================================================
   // Geometry
   localparam int FIRST_W    = 11;
   localparam int SECOND_W   = 5;
   localparam int SECOND_LOW = 27;
   localparam int PIN_W      = FIRST_W + SECOND_W;
   localparam int SEL_W      = 3;
   localparam int CLK_IN_N   = 8;
   localparam int CLK_SEL_W  = 3;
   localparam int SYNC_DEPTH = 2;

   // ==========================================================================
   // Pin indices in the packed pin vector
   localparam int PIN_FIRST_0   = 0;
   localparam int PIN_FIRST_1   = 1;
   localparam int PIN_FIRST_2   = 2;
   localparam int PIN_FIRST_3   = 3;
   localparam int PIN_FIRST_4   = 4;
   localparam int PIN_FIRST_5   = 5;
   localparam int PIN_FIRST_6   = 6;
   localparam int PIN_FIRST_7   = 7;
   localparam int PIN_FIRST_8   = 8;
   localparam int PIN_FIRST_9   = 9;
   localparam int PIN_FIRST_10  = 10;
   localparam int PIN_SECOND_27 = 11;
   localparam int PIN_SECOND_28 = 12;
   localparam int PIN_SECOND_29 = 13;
   localparam int PIN_SECOND_30 = 14;
   localparam int PIN_SECOND_31 = 15;

   // ==========================================================================
   // Reset values and capability masks
   localparam logic [PIN_W-1:0] OD_CAPABLE   = 16'hfa00;
   localparam logic [PIN_W-1:0] PIN_OUT_RST  = 16'h0000;
   localparam logic [PIN_W-1:0] PIN_OE_N_RST = 16'hffff;
   localparam logic [PIN_W-1:0] PIN_READ_RST = 16'h0000;

   // ==========================================================================
   // Function select codes
   typedef enum logic [SEL_W-1:0] {
      PMX_FN_GPIO = 3'h0,
      PMX_FN_ALT1 = 3'h1,
      PMX_FN_ALT2 = 3'h3,
      PMX_FN_ALT3 = 3'h2,
      PMX_FN_ALT4 = 3'h6
   } pmx_func_e;

   // ==========================================================================
   // Peripheral to pin
   typedef struct packed {
      logic       tdm_a_tx_data;
      logic [3:0] timer_output;
      logic [3:0] baud_gen_out;
      logic       spi_master_mode;
      logic       spi_serial_clock_pin;
      logic       spi_master_out_pin;
      logic       spi_master_in_pin;
      logic       cam_frame_start_chan_two;
      logic       two_wire_data_pin;
      logic       two_wire_data_drive;
   } pmx_periph_out_s;

   // Pin to peripheral
   typedef struct packed {
      logic                tdm_a_rx_data;
      logic                tdm_b_rx_data;
      logic [CLK_IN_N-1:0] serial_clock_in;
      logic [3:0]          timer_ext_clock;
      logic                tdm_a_rx_clock;
      logic                tdm_a_tx_clock;
      logic                tdm_b_rx_clock;
      logic                tdm_b_tx_clock;
      logic [1:0]          baud_gen_ext_clock;
      logic                spi_slave_select_in;
      logic                spi_serial_clock_pin;
      logic                spi_master_out_pin;
      logic                spi_master_in_pin;
      logic                cam_reject_chan_one;
      logic                two_wire_data_pin;
   } pmx_periph_in_s;

endpackage

/* File: pmx_sync.sv */
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Inputs are asynchronous to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module pmx_sync
   import pmx_pkg::*;
#(
   parameter int WIDTH = PIN_W
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } pmx_sync_s;

   pmx_sync_s state;
   pmx_sync_s next_state;

   initial begin
      if (WIDTH < 1) $error("pmx_sync: WIDTH must be at least 1");
   end

   // ==========================================================================
   // Stage update
   always_comb begin
      next_state.meta   = async_i;
      next_state.stable = state.meta;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_o = state.stable;

endmodule

`default_nettype wire

/* File: pmx_pin_mux.sv */
// Purpose: Pin-function mux for first port lines 10..0 and second port lines 31..27
// Assumes: Select, direction, data and open-drain ports come from clk_i-domain logic
// Notes:   Pin inputs are synchronised; pin drive and peripheral inputs are registered
//
// Notes on behaviour
// RQ1 - First port line 10: GPIO or TDM port B receive data input.
// RQ2 - First port line 9: GPIO or TDM port A transmit data, open-drain optional.
// RQ3 - First port line 8: GPIO or TDM port A receive data input.
// RQ4 - Line 7: GPIO, clock in 1, timer 1 clock, TDM A rx clock, baud 1 out.
// RQ5 - Line 6: GPIO, clock in 2, timer 1 output, baud external clock one.
// RQ6 - Line 5: GPIO, clock in 3, timer 2 clock, TDM A tx clock, baud 2 out.
// RQ7 - Line 4: GPIO, clock in 4, timer 2 output; high impedance during reset.
// RQ8 - Line 3: GPIO, clock in 5, timer 3 clock, baud 3 output.
// RQ9 - Line 2: GPIO, clock in 6, timer 3 out, TDM B rx clock, baud clock two.
// RQ10 - Line 1: GPIO, clock in 7, timer 4 clock, baud 4 output.
// RQ11 - Line 0: GPIO, clock in 8, timer 4 output, TDM B tx clock.
// RQ12 - Eight clock inputs each routable to serial comm and mgmt channels.
// RQ13 - Second port 31: GPIO, SPI slave select, CAM reject one; open-drain optional.
// RQ14 - Line 30: SPI clock out as master, in as slave, or CAM frame start two.
// RQ15 - Line 29: SPI master-out drives as master, samples as slave.
// RQ16 - Line 28: SPI master-in samples as master, drives as slave, or baud 4.
// RQ17 - Line 27: GPIO, two-wire data, baud 1 out; high impedance in reset.
// RQ18 - Per-pin function select and per-pin open-drain enable where supported.
// RQ19 - After reset every pin is a GPIO input with its driver off.
`timescale 1ns/1ps
`default_nettype none

module pmx_pin_mux
   import pmx_pkg::*;
#(
   parameter int NUM_SCC = 2,
   parameter int NUM_SMC = 2
) (
   input  wire logic                                clk_i,
   input  wire logic                                reset_i,
   input  wire logic [FIRST_W-1:0]                  first_gp_port_in_i,
   output var  logic [FIRST_W-1:0]                  first_gp_port_out_o,
   output var  logic [FIRST_W-1:0]                  first_gp_port_oe_n_o,
   input  wire logic [SECOND_W-1:0]                 second_gp_port_in_i,
   output var  logic [SECOND_W-1:0]                 second_gp_port_out_o,
   output var  logic [SECOND_W-1:0]                 second_gp_port_oe_n_o,
   input  wire logic [FIRST_W-1:0][SEL_W-1:0]       first_sel_i,
   input  wire logic [SECOND_W-1:0][SEL_W-1:0]      second_sel_i,
   input  wire logic [FIRST_W-1:0]                  first_dir_i,
   input  wire logic [SECOND_W-1:0]                 second_dir_i,
   input  wire logic [FIRST_W-1:0]                  first_data_i,
   input  wire logic [SECOND_W-1:0]                 second_data_i,
   input  wire logic [FIRST_W-1:0]                  first_od_en_i,
   input  wire logic [SECOND_W-1:0]                 second_od_en_i,
   output var  logic [FIRST_W-1:0]                  first_read_o,
   output var  logic [SECOND_W-1:0]                 second_read_o,
   input  wire pmx_periph_out_s                     periph_out_i,
   output var  pmx_periph_in_s                      periph_in_o,
   input  wire logic [NUM_SCC-1:0][CLK_SEL_W-1:0]   scc_clk_sel_i,
   input  wire logic [NUM_SMC-1:0][CLK_SEL_W-1:0]   smc_clk_sel_i,
   output var  logic [NUM_SCC-1:0]                  scc_clock_o,
   output var  logic [NUM_SMC-1:0]                  smc_clock_o
);

   // ==========================================================================
   // State
   typedef struct packed {
      logic [PIN_W-1:0]   pin_out;
      logic [PIN_W-1:0]   pin_oe_n;
      logic [PIN_W-1:0]   pin_read;
      pmx_periph_in_s     periph;
      logic [NUM_SCC-1:0] scc_clock;
      logic [NUM_SMC-1:0] smc_clock;
   } pmx_state_s;

   pmx_state_s       state;
   pmx_state_s       next_state;
   logic [PIN_W-1:0] pin_sync;

   initial begin
      if (NUM_SCC < 1 || NUM_SCC > 4) $error("pmx_pin_mux: NUM_SCC out of range");
      if (NUM_SMC < 1 || NUM_SMC > 2) $error("pmx_pin_mux: NUM_SMC out of range");
   end

   function automatic logic is_fn(input logic [SEL_W-1:0] sel, input pmx_func_e fn);
      return sel == fn;
   endfunction

   // ==========================================================================
   // Pin input synchroniser
   pmx_sync #(
      .WIDTH   (PIN_W)
   ) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({second_gp_port_in_i, first_gp_port_in_i}),
      .sync_o  (pin_sync)
   );

   // ==========================================================================
   // Mux
   always_comb begin
      logic [PIN_W-1:0][SEL_W-1:0] sel;
      logic [PIN_W-1:0]            dir;
      logic [PIN_W-1:0]            gdat;
      logic [PIN_W-1:0]            od_en;
      logic [PIN_W-1:0]            drv;
      logic [PIN_W-1:0]            val;
      logic [PIN_W-1:0]            f1;
      logic [PIN_W-1:0]            f2;
      logic [PIN_W-1:0]            f3;
      logic [PIN_W-1:0]            f4;
      pmx_periph_out_s             po;
      pmx_periph_in_s              pi;
      logic [PIN_W-1:0]            p;
      sel   = {second_sel_i, first_sel_i};
      dir   = {second_dir_i, first_dir_i};
      gdat  = {second_data_i, first_data_i};
      od_en = {second_od_en_i, first_od_en_i};
      po    = periph_out_i;
      p     = pin_sync;
      drv   = '0;
      val   = '0;
      pi    = '0;

      // Function decode and GPIO use on every pin
      for (int i = 0; i < PIN_W; i++) begin
         f1[i] = is_fn(sel[i], PMX_FN_ALT1);
         f2[i] = is_fn(sel[i], PMX_FN_ALT2);
         f3[i] = is_fn(sel[i], PMX_FN_ALT3);
         f4[i] = is_fn(sel[i], PMX_FN_ALT4);
         if (is_fn(sel[i], PMX_FN_GPIO)) begin
            drv[i] = dir[i]; // RQ18
            val[i] = gdat[i];
         end
      end

      // First port line 10
      pi.tdm_b_rx_data = f1[PIN_FIRST_10] & p[PIN_FIRST_10]; // RQ1

      // First port line 9
      if (f1[PIN_FIRST_9]) begin
         drv[PIN_FIRST_9] = 1'b1; // RQ2
         val[PIN_FIRST_9] = po.tdm_a_tx_data;
      end

      // First port line 8
      pi.tdm_a_rx_data = f1[PIN_FIRST_8] & p[PIN_FIRST_8]; // RQ3

      // Clock input alternates on first port lines 7..0
      for (int i = 0; i < CLK_IN_N; i++) begin
         pi.serial_clock_in[i] = f1[7-i] & p[7-i]; // RQ12
      end

      // First port line 7
      pi.timer_ext_clock[0] = f2[PIN_FIRST_7] & p[PIN_FIRST_7]; // RQ4
      pi.tdm_a_rx_clock     = f3[PIN_FIRST_7] & p[PIN_FIRST_7]; // RQ4
      if (f4[PIN_FIRST_7]) begin
         drv[PIN_FIRST_7] = 1'b1; // RQ4
         val[PIN_FIRST_7] = po.baud_gen_out[0];
      end

      // First port line 6
      if (f2[PIN_FIRST_6]) begin
         drv[PIN_FIRST_6] = 1'b1; // RQ5
         val[PIN_FIRST_6] = po.timer_output[0];
      end
      pi.baud_gen_ext_clock[0] = f3[PIN_FIRST_6] & p[PIN_FIRST_6]; // RQ5

      // First port line 5
      pi.timer_ext_clock[1] = f2[PIN_FIRST_5] & p[PIN_FIRST_5]; // RQ6
      pi.tdm_a_tx_clock     = f3[PIN_FIRST_5] & p[PIN_FIRST_5]; // RQ6
      if (f4[PIN_FIRST_5]) begin
         drv[PIN_FIRST_5] = 1'b1; // RQ6
         val[PIN_FIRST_5] = po.baud_gen_out[1];
      end

      // First port line 4
      if (f2[PIN_FIRST_4]) begin
         drv[PIN_FIRST_4] = 1'b1; // RQ7
         val[PIN_FIRST_4] = po.timer_output[1];
      end

      // First port line 3
      pi.timer_ext_clock[2] = f2[PIN_FIRST_3] & p[PIN_FIRST_3]; // RQ8
      if (f3[PIN_FIRST_3]) begin
         drv[PIN_FIRST_3] = 1'b1; // RQ8
         val[PIN_FIRST_3] = po.baud_gen_out[2];
      end

      // First port line 2
      if (f2[PIN_FIRST_2]) begin
         drv[PIN_FIRST_2] = 1'b1; // RQ9
         val[PIN_FIRST_2] = po.timer_output[2];
      end
      pi.tdm_b_rx_clock        = f3[PIN_FIRST_2] & p[PIN_FIRST_2]; // RQ9
      pi.baud_gen_ext_clock[1] = f4[PIN_FIRST_2] & p[PIN_FIRST_2]; // RQ9

      // First port line 1
      pi.timer_ext_clock[3] = f2[PIN_FIRST_1] & p[PIN_FIRST_1]; // RQ10
      if (f3[PIN_FIRST_1]) begin
         drv[PIN_FIRST_1] = 1'b1; // RQ10
         val[PIN_FIRST_1] = po.baud_gen_out[3];
      end

      // First port line 0
      if (f2[PIN_FIRST_0]) begin
         drv[PIN_FIRST_0] = 1'b1; // RQ11
         val[PIN_FIRST_0] = po.timer_output[3];
      end
      pi.tdm_b_tx_clock = f3[PIN_FIRST_0] & p[PIN_FIRST_0]; // RQ11

      // Second port line 31
      pi.spi_slave_select_in = f1[PIN_SECOND_31] & p[PIN_SECOND_31]; // RQ13
      pi.cam_reject_chan_one = f2[PIN_SECOND_31] & p[PIN_SECOND_31]; // RQ13

      // Second port line 30
      if (f1[PIN_SECOND_30]) begin
         drv[PIN_SECOND_30] = po.spi_master_mode; // RQ14
         val[PIN_SECOND_30] = po.spi_serial_clock_pin;
         pi.spi_serial_clock_pin = ~po.spi_master_mode & p[PIN_SECOND_30]; // RQ14
      end
      if (f2[PIN_SECOND_30]) begin
         drv[PIN_SECOND_30] = 1'b1; // RQ14
         val[PIN_SECOND_30] = po.cam_frame_start_chan_two;
      end

      // Second port line 29
      if (f1[PIN_SECOND_29]) begin
         drv[PIN_SECOND_29] = po.spi_master_mode; // RQ15
         val[PIN_SECOND_29] = po.spi_master_out_pin;
         pi.spi_master_out_pin = ~po.spi_master_mode & p[PIN_SECOND_29]; // RQ15
      end

      // Second port line 28
      if (f1[PIN_SECOND_28]) begin
         drv[PIN_SECOND_28] = ~po.spi_master_mode; // RQ16
         val[PIN_SECOND_28] = po.spi_master_in_pin;
         pi.spi_master_in_pin = po.spi_master_mode & p[PIN_SECOND_28]; // RQ16
      end
      if (f2[PIN_SECOND_28]) begin
         drv[PIN_SECOND_28] = 1'b1; // RQ16
         val[PIN_SECOND_28] = po.baud_gen_out[3];
      end

      // Second port line 27
      if (f1[PIN_SECOND_27]) begin
         drv[PIN_SECOND_27] = po.two_wire_data_drive; // RQ17
         val[PIN_SECOND_27] = po.two_wire_data_pin;
         pi.two_wire_data_pin = p[PIN_SECOND_27]; // RQ17
      end
      if (f2[PIN_SECOND_27]) begin
         drv[PIN_SECOND_27] = 1'b1; // RQ17
         val[PIN_SECOND_27] = po.baud_gen_out[0];
      end

      // Open-drain and pin registers; an illegal code sets no driver
      for (int i = 0; i < PIN_W; i++) begin
         if (OD_CAPABLE[i] && od_en[i]) begin
            drv[i] = drv[i] & ~val[i]; // RQ18
            val[i] = 1'b0;
         end
         next_state.pin_oe_n[i] = ~drv[i];
         next_state.pin_out[i]  = drv[i] & val[i];
      end
      next_state.pin_read = p;
      next_state.periph   = pi;

      // Clock routing to channels
      for (int c = 0; c < NUM_SCC; c++) begin
         next_state.scc_clock[c] = pi.serial_clock_in[scc_clk_sel_i[c]]; // RQ12
      end
      for (int c = 0; c < NUM_SMC; c++) begin
         next_state.smc_clock[c] = pi.serial_clock_in[smc_clk_sel_i[c]]; // RQ12
      end
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state.pin_out   <= PIN_OUT_RST;
         state.pin_oe_n  <= PIN_OE_N_RST; // RQ7 RQ17 RQ19
         state.pin_read  <= PIN_READ_RST;
         state.periph    <= '0;
         state.scc_clock <= '0;
         state.smc_clock <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================================
   // Outputs
   assign first_gp_port_out_o   = state.pin_out[FIRST_W-1:0];
   assign first_gp_port_oe_n_o  = state.pin_oe_n[FIRST_W-1:0];
   assign second_gp_port_out_o  = state.pin_out[PIN_W-1:FIRST_W];
   assign second_gp_port_oe_n_o = state.pin_oe_n[PIN_W-1:FIRST_W];
   assign first_read_o          = state.pin_read[FIRST_W-1:0];
   assign second_read_o         = state.pin_read[PIN_W-1:FIRST_W];
   assign periph_in_o           = state.periph;
   assign scc_clock_o           = state.scc_clock;
   assign smc_clock_o           = state.smc_clock;

endmodule

`default_nettype wire

/* File: pmx_pin_mux_properties.sv */
// Purpose: Port-level assertions for the pin-function mux
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound into every pmx_pin_mux instance
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_mux_properties
   import pmx_pkg::*;
#(
   parameter int NUM_SCC = 2,
   parameter int NUM_SMC = 2
) (
   input wire logic                             clk_i,
   input wire logic                             reset_i,
   input wire logic [FIRST_W-1:0]               first_gp_port_in_i,
   input wire logic [FIRST_W-1:0]               first_gp_port_out_o,
   input wire logic [FIRST_W-1:0]               first_gp_port_oe_n_o,
   input wire logic [SECOND_W-1:0]              second_gp_port_out_o,
   input wire logic [SECOND_W-1:0]              second_gp_port_oe_n_o,
   input wire logic [FIRST_W-1:0][SEL_W-1:0]    first_sel_i,
   input wire logic [SECOND_W-1:0][SEL_W-1:0]   second_sel_i,
   input wire logic [FIRST_W-1:0]               first_od_en_i,
   input wire logic [SECOND_W-1:0]              second_od_en_i,
   input wire logic [FIRST_W-1:0]               first_read_o,
   input wire pmx_periph_out_s                  periph_out_i,
   input wire pmx_periph_in_s                   periph_in_o,
   input wire logic [NUM_SCC-1:0][CLK_SEL_W-1:0] scc_clk_sel_i,
   input wire logic [NUM_SCC-1:0]               scc_clock_o
);
   // ======
   // Edges since reset release
   logic [1:0] up;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ======
   // Assertions
   chk_reset_hiz: assert property (disable iff (1'b0) reset_i |->
      &{second_gp_port_oe_n_o, first_gp_port_oe_n_o} && !first_read_o
      && !{second_gp_port_out_o, first_gp_port_out_o}) else $error("pins not idle in reset");
   chk_off_quiet: assert property (!(first_gp_port_out_o & first_gp_port_oe_n_o)
      && !(second_gp_port_out_o & second_gp_port_oe_n_o)) else $error("released pin shows 1");
   chk_illegal_off: assert property (first_sel_i[10] inside {3'h4, 3'h5, 3'h7}
      |=> first_gp_port_oe_n_o[10]) else $error("bad code drives pin");
   chk_tdm_tx_od: assert property (first_sel_i[9] == PMX_FN_ALT1 |=>
      first_gp_port_oe_n_o[9] == ($past(first_od_en_i[9]) && $past(periph_out_i.tdm_a_tx_data))
      && first_gp_port_out_o[9] == (!$past(first_od_en_i[9]) && $past(periph_out_i.tdm_a_tx_data)))
      else $error("tdm tx drive wrong");
   chk_read_sync: assert property (up == 2'h3 |->
      first_read_o == $past(first_gp_port_in_i, 3)) else $error("read latency wrong");
   chk_clk_route: assert property (first_sel_i[7] == PMX_FN_ALT1 ##1 up == 2'h3 |->
      periph_in_o.serial_clock_in[0] == $past(first_gp_port_in_i[7], 3))
      else $error("clock input one wrong");
   chk_scc_route: assert property ($past(scc_clk_sel_i[0]) == 3'h0
      && $past(first_sel_i[7]) == PMX_FN_ALT1 |-> scc_clock_o[0] == periph_in_o.serial_clock_in[0])
      else $error("scc clock route wrong");
   chk_spi_clk_dir: assert property (second_sel_i[3] == PMX_FN_ALT1 && !second_od_en_i[3]
      |=> second_gp_port_oe_n_o[3] == !$past(periph_out_i.spi_master_mode))
      else $error("spi clock direction wrong");
   chk_miso_dir: assert property (second_sel_i[1] == PMX_FN_ALT1 && !second_od_en_i[1]
      |=> second_gp_port_oe_n_o[1] == $past(periph_out_i.spi_master_mode))
      else $error("spi miso direction wrong");
   chk_twd_dir: assert property (second_sel_i[0] == PMX_FN_ALT1 && !second_od_en_i[0]
      |=> second_gp_port_oe_n_o[0] == !$past(periph_out_i.two_wire_data_drive))
      else $error("two-wire drive wrong");
   cover property (first_sel_i[9] == PMX_FN_ALT1 && first_od_en_i[9]);
   cover property (second_sel_i[3] == PMX_FN_ALT1 && periph_out_i.spi_master_mode);
   cover property (scc_clk_sel_i[0] == 3'h0 && first_sel_i[7] == PMX_FN_ALT1);
endmodule
bind pmx_pin_mux pmx_pin_mux_properties #(.NUM_SCC(NUM_SCC), .NUM_SMC(NUM_SMC)) u_chk (.*);
`default_nettype wire

/* File: pmx_pin_model.sv */
// Purpose: Board side of the mux pins
// Assumes: Device drive wins when its enable is low
// Notes:   Pins driven by neither the device nor ext_i toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_model
   import pmx_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic [PIN_W-1:0] out_i,
   input  wire logic [PIN_W-1:0] oe_n_i,
   input  wire logic [PIN_W-1:0] ext_i,
   input  wire logic [PIN_W-1:0] ext_en_i,
   output var  logic [PIN_W-1:0] pin_o
);
   logic [PIN_W-1:0] last = '0;
   always_ff @(posedge clk_i) last <= pin_o;
   // ======
   // Wire resolution
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         if (!oe_n_i[i]) pin_o[i] = out_i[i];
         else if (ext_en_i[i]) pin_o[i] = ext_i[i];
         else pin_o[i] = ~last[i];
      end
   end
endmodule
`default_nettype wire

/* File: test_port_ab_pin_function_mux.sv */
// Purpose: Self-checking bench for the pin-function mux
// Assumes: Far-side pins come from pmx_pin_model
// Notes:   Each random setup settles 6 cycles before its checks
`timescale 1ns/1ps
`default_nettype none
module test_port_ab_pin_function_mux
   import pmx_pkg::*;
;
   typedef struct {
      int          w;
      logic [15:0] e;
      logic [15:0] m;
   } pmx_note_s;
   logic                            clk = 1'b0;
   logic                            rst = 1'b0;
   logic [PIN_W-1:0][SEL_W-1:0]     sel = '0;
   logic [PIN_W-1:0]                dir = '0, dat = '0, od = '0, ext = '0, ext_en = '0;
   wire  logic [PIN_W-1:0]          oe_n, pout, pin, rd;
   logic [1:0][CLK_SEL_W-1:0]       scs = '0, sms = '0;
   logic [1:0]                      serial_comm_channel, serial_mgmt_channel;
   pmx_periph_out_s                 po = '0;
   pmx_periph_in_s                  pi;
   logic [31:0]                     rs = 32'ha466;
   int                              err_count = 0, num_checks = 0, cyc = 0;
   pmx_note_s                       q[$], n;
   string                           nm[4] = '{"oe_n", "out", "read", "clk_in"};
   pmx_pin_mux DUT (
      .clk_i(clk), .reset_i(rst),
      .first_gp_port_in_i(pin[10:0]), .first_gp_port_out_o(pout[10:0]),
      .first_gp_port_oe_n_o(oe_n[10:0]), .second_gp_port_in_i(pin[15:11]),
      .second_gp_port_out_o(pout[15:11]), .second_gp_port_oe_n_o(oe_n[15:11]),
      .first_sel_i(sel[10:0]), .second_sel_i(sel[15:11]),
      .first_dir_i(dir[10:0]), .second_dir_i(dir[15:11]),
      .first_data_i(dat[10:0]), .second_data_i(dat[15:11]),
      .first_od_en_i(od[10:0]), .second_od_en_i(od[15:11]),
      .first_read_o(rd[10:0]), .second_read_o(rd[15:11]),
      .periph_out_i(po), .periph_in_o(pi), .scc_clk_sel_i(scs), .smc_clk_sel_i(sms),
      .scc_clock_o(serial_comm_channel), .smc_clock_o(serial_mgmt_channel));
   pmx_pin_model PM (.clk_i(clk), .out_i(pout), .oe_n_i(oe_n), .ext_i(ext),
      .ext_en_i(ext_en), .pin_o(pin));
   // ======
   // Clock, timeout, helpers
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         summarize();
      end
   end
   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic logic [1:0] drv(int p, logic [2:0] c);
      if (c == PMX_FN_GPIO) return {dir[p], dat[p]};
      case ({p[3:0], c})
         {4'd9, PMX_FN_ALT1}: return {1'b1, po.tdm_a_tx_data};
         {4'd7, PMX_FN_ALT4}: return {1'b1, po.baud_gen_out[0]};
         {4'd6, PMX_FN_ALT2}: return {1'b1, po.timer_output[0]};
         {4'd5, PMX_FN_ALT4}: return {1'b1, po.baud_gen_out[1]};
         {4'd4, PMX_FN_ALT2}: return {1'b1, po.timer_output[1]};
         {4'd3, PMX_FN_ALT3}: return {1'b1, po.baud_gen_out[2]};
         {4'd2, PMX_FN_ALT2}: return {1'b1, po.timer_output[2]};
         {4'd1, PMX_FN_ALT3}: return {1'b1, po.baud_gen_out[3]};
         {4'd0, PMX_FN_ALT2}: return {1'b1, po.timer_output[3]};
         {4'd14, PMX_FN_ALT1}: return {po.spi_master_mode, po.spi_serial_clock_pin};
         {4'd14, PMX_FN_ALT2}: return {1'b1, po.cam_frame_start_chan_two};
         {4'd13, PMX_FN_ALT1}: return {po.spi_master_mode, po.spi_master_out_pin};
         {4'd12, PMX_FN_ALT1}: return {~po.spi_master_mode, po.spi_master_in_pin};
         {4'd12, PMX_FN_ALT2}: return {1'b1, po.baud_gen_out[3]};
         {4'd11, PMX_FN_ALT1}: return {po.two_wire_data_drive, po.two_wire_data_pin};
         {4'd11, PMX_FN_ALT2}: return {1'b1, po.baud_gen_out[0]};
         default: return 2'b00;
      endcase
   endfunction
   task automatic check(string s, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic note(int w, logic [15:0] e, logic [15:0] m);
      q.push_back('{w, e, m});
   endtask
   function automatic logic [15:0] obs(int w);
      case (w)
         0: return oe_n;
         1: return pout;
         2: return rd;
         default: return {4'h0, serial_mgmt_channel, serial_comm_channel, pi.serial_clock_in};
      endcase
   endfunction
   // ======
   // Monitor takes every queued note, oldest first
   always @(negedge clk) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         check(nm[n.w], obs(n.w) & n.m, n.e & n.m);
      end
   end
   // ======
   // Driver tasks
   task automatic hold_rst(int k);
      rst <= 1'b1;
      repeat (k) @(posedge clk);
      note(0, 16'hffff, 16'hffff);
      note(1, 16'h0000, 16'hffff);
      note(2, 16'h0000, 16'hffff);
      rst <= 1'b0;
   endtask
   task automatic settle();
      logic [1:0]  d;
      logic [15:0] eo, ev, ep, m;
      logic [15:0] ec, cm;
      logic [3:0][2:0] rt;
      repeat (6) @(posedge clk);
      cm = '0;
      rt = {sms, scs};
      for (int p = 0; p < PIN_W; p++) begin
         d = drv(p, sel[p]);
         d[1] = d[1] & ~(OD_CAPABLE[p] & od[p] & d[0]);
         eo[p] = ~d[1];
         ev[p] = d[1] & d[0];
         ep[p] = d[1] ? d[0] : ext[p];
         m[p] = d[1] | ext_en[p];
      end
      for (int i = 0; i < 8; i++) begin
         ec[i] = (sel[7-i] == PMX_FN_ALT1) & ep[7-i];
         cm[i] = (sel[7-i] != PMX_FN_ALT1) | m[7-i];
      end
      for (int c = 0; c < 4; c++) begin
         ec[8+c] = ec[rt[c]];
         cm[8+c] = cm[rt[c]];
      end
      note(0, eo, 16'hffff);
      note(1, ev, 16'hffff);
      note(2, ep, m);
      note(3, ec, cm);
   endtask
   task automatic rnd_step(int md);
      logic [4:0][2:0] codes;
      codes = {3'h6, 3'h2, 3'h3, 3'h1, 3'h0};
      for (int p = 0; p < PIN_W; p++) begin
         rs = xs(rs);
         sel[p] <= (md == 1) ? (rs[1] ? 3'h4 : (rs[0] ? 3'h5 : 3'h7)) : codes[rs[18:16] % 3'd5];
      end
      rs = xs(rs);
      dir <= rs[15:0];
      dat <= rs[31:16];
      rs = xs(rs);
      od <= rs[15:0];
      ext <= rs[31:16];
      rs = xs(rs);
      po <= rs[15:0];
      ext_en <= rs[31:16] | rs[23:8];
      rs = xs(rs);
      scs <= rs[5:0];
      sms <= rs[11:6];
      if (md == 2) begin
         sel[7] <= PMX_FN_ALT1;
         scs[0] <= 3'h0;
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ======
   // Main sequence
   initial begin
      hold_rst(16);
      settle();
      $display("test reset defaults done");
      for (int k = 0; k < 60; k++) begin
         rnd_step((k % 10 == 3) ? 1 : ((k % 10 == 5) ? 2 : 0));
         settle();
      end
      $display("test random functions done");
      rnd_step(0);
      repeat (2) @(posedge clk);
      hold_rst(3);
      settle();
      $display("test mid-run reset done");
      repeat (2) @(negedge clk);
      summarize();
   end
endmodule
`default_nettype wire
